// ==== src/data_space_pkg.sv ====
// Shared constants and carrier types for the data-space decoder.
// Assumes one 50 MHz core clock and an 8-bit external-data bus.
package data_space_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] SCRATCH_BASE = 16'h0000;
  localparam logic [15:0] SCRATCH_LAST = 16'h0FFF;
  localparam int SCRATCH_BYTES = 4096;
  localparam logic [15:0] INFO_BASE = 16'h3000;
  localparam logic [15:0] INFO_LAST = 16'h33FF;
  localparam int INFO_AW = 10;
  // Peripheral windows: group A keeps state across Level 2/3 resets
  localparam logic [15:0] PERIPH_A_BASE = 16'h2000;
  localparam logic [15:0] PERIPH_A_LAST = 16'h27FF;
  localparam logic [15:0] PERIPH_B_BASE = 16'h2800;
  localparam logic [15:0] PERIPH_B_LAST = 16'h2FFF;
  localparam int PERIPH_AW = 11;

  // ----------------------------------------------------------------
  // Info field offsets; bits above INFO_AW fold into the window
  // ----------------------------------------------------------------
  localparam logic [11:0] INFO_FIELD_FIRST = 12'h401;
  localparam logic [11:0] INFO_FIELD_LAST = 12'h41E;
  localparam logic [11:0] COEF_GROUP0 = 12'h420;
  localparam logic [11:0] COEF_GROUP1 = 12'h438;
  localparam logic [11:0] COEF_GROUP2 = 12'h450;
  localparam int COEF_WORDS = 5;
  localparam int COEF_WORD_BYTES = 4;
  localparam int CHECKSUM_OFS = 20;   // group_checksum_word, 2 bytes LSB first
  localparam int GROUP_BYTES = 24;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int INFO_SETTLE_NS = 2000000;
  localparam int INFO_SETTLE_CYCLES = (INFO_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xbus_req_t;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [PERIPH_AW-1:0] addr;
    logic [7:0] wdata;
  } periph_req_t;

  typedef enum logic [3:0] {
    SRC_NONE = 4'b0001,
    SRC_RAM = 4'b0010,
    SRC_INFO = 4'b0100,
    SRC_PERIPH = 4'b1000
  } rd_src_t;

  typedef enum logic [1:0] {
    BOOT_SETTLE = 2'b01,
    BOOT_RUN = 2'b10
  } boot_state_t;

endpackage

// ==== src/scratch_ram_mem.sv ====
// Byte-wide scratch RAM with registered read data.
// Assumes single-port use; contents have no reset at all.
`timescale 1ns/10ps
module scratch_ram_mem #(
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("scratch_ram_mem: DEPTH must equal 2**AW");
  end

  logic [7:0] mem [DEPTH];

  // Storage and read port, never touched by any reset
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule

// ==== src/data_space_decoder.sv ====
// Data-space decoder: scratch RAM, read-only info area and two
// peripheral reset domains behind the MCU external-data bus.
// Assumes info contents come from a factory array outside this block.
`timescale 1ns/10ps

module data_space_decoder
  import data_space_pkg::*;
#(
  parameter int SETTLE_CYCLES = data_space_pkg::INFO_SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rst_l23,
  input data_space_pkg::xbus_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic fetch_enable,
  output logic [data_space_pkg::INFO_AW-1:0] info_addr,
  output logic info_rd,
  input wire logic [7:0] info_rdata,
  output data_space_pkg::periph_req_t periph_a_req,
  output data_space_pkg::periph_req_t periph_b_req,
  input wire logic [7:0] periph_a_rdata,
  input wire logic [7:0] periph_b_rdata,
  output logic periph_a_rst,
  output logic periph_b_rst,
  output logic info_wr_ignored
);
  import data_space_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("data_space_decoder: SETTLE_CYCLES must be at least 1");
  end

  // Windows must not overlap, or the priority decode hides one
  if (SCRATCH_LAST >= PERIPH_A_BASE || PERIPH_A_LAST >= PERIPH_B_BASE ||
      PERIPH_B_LAST >= INFO_BASE) begin : g_bad_map
    $error("data_space_decoder: address windows overlap");
  end

  // Info window must span exactly the info address width
  if (int'(INFO_LAST) - int'(INFO_BASE) + 1 != (1 << INFO_AW)) begin : g_bad_info
    $error("data_space_decoder: info window and INFO_AW disagree");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Scratch RAM address width follows its byte count
  localparam int SCRATCH_AW = $clog2(SCRATCH_BYTES);

  // Region hits and read return state
  logic hit_ram;
  logic hit_info;
  logic hit_pa;
  logic hit_pb;
  logic [7:0] ram_q;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  rd_src_t src_r;
  rd_src_t src_nxt;

  // Range match for each region
  always_comb begin
    hit_ram = 1'b0;
    hit_info = 1'b0;
    hit_pa = 1'b0;
    hit_pb = 1'b0;
    if (cpu_req.addr <= SCRATCH_LAST) begin
      hit_ram = 1'b1;
    end else if (cpu_req.addr >= INFO_BASE && cpu_req.addr <= INFO_LAST) begin
      hit_info = 1'b1;
    end else if (cpu_req.addr >= PERIPH_A_BASE && cpu_req.addr <= PERIPH_A_LAST) begin
      hit_pa = 1'b1;
    end else if (cpu_req.addr >= PERIPH_B_BASE && cpu_req.addr <= PERIPH_B_LAST) begin
      hit_pb = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Scratch RAM
  // ----------------------------------------------------------------
  // Writes land at the taking edge; no reset reaches the array
  scratch_ram_mem #(
    .DEPTH(SCRATCH_BYTES),
    .AW(SCRATCH_AW)
  ) i_scratch_ram_mem (
    .core_clk(core_clk),
    .we(cpu_req.wr && hit_ram),
    .re(cpu_req.rd && hit_ram),
    .addr(cpu_req.addr[SCRATCH_AW-1:0]),
    .wdata(cpu_req.wdata),
    .rdata(ram_q)
  );

  // ----------------------------------------------------------------
  // Info area and peripheral strobes
  // ----------------------------------------------------------------
  // Info array is addressed like a peripheral; no write path exists
  assign info_addr = cpu_req.addr[INFO_AW-1:0];
  assign info_rd = cpu_req.rd && hit_info;

  // Peripheral requests, combinational handshake
  always_comb begin
    periph_a_req.sel = hit_pa && (cpu_req.rd || cpu_req.wr);
    periph_a_req.rd = cpu_req.rd && hit_pa;
    periph_a_req.wr = cpu_req.wr && hit_pa;
    periph_a_req.addr = cpu_req.addr[PERIPH_AW-1:0];
    periph_a_req.wdata = cpu_req.wdata;
    periph_b_req.sel = hit_pb && (cpu_req.rd || cpu_req.wr);
    periph_b_req.rd = cpu_req.rd && hit_pb;
    periph_b_req.wr = cpu_req.wr && hit_pb;
    periph_b_req.addr = cpu_req.addr[PERIPH_AW-1:0];
    periph_b_req.wdata = cpu_req.wdata;
  end

  // ----------------------------------------------------------------
  // Reset domains
  // ----------------------------------------------------------------
  // Group A follows Level 1 only, group B any level
  assign periph_a_rst = rst;
  assign periph_b_rst = rst | rst_l23;

  // ----------------------------------------------------------------
  // Read return path
  // ----------------------------------------------------------------
  // Source select and captured data for the next cycle
  always_comb begin
    src_nxt = SRC_NONE;
    hold_nxt = UNMAPPED_DATA;
    if (cpu_req.rd) begin
      if (hit_ram) begin
        src_nxt = SRC_RAM;
      end else if (hit_info) begin
        src_nxt = SRC_INFO;
        hold_nxt = info_rdata;
      end else if (hit_pa) begin
        src_nxt = SRC_PERIPH;
        hold_nxt = periph_a_rdata;
      end else if (hit_pb) begin
        src_nxt = SRC_PERIPH;
        hold_nxt = periph_b_rdata;
      end
    end
  end

  // Read source and valid flag, cleared by Level 1 or 2/3
  always_ff @(posedge core_clk) begin
    if (rst || rst_l23) begin
      src_r <= SRC_NONE;
      cpu_rvalid <= 1'b0;
    end else begin
      src_r <= src_nxt;
      cpu_rvalid <= cpu_req.rd;
    end
  end

  // Captured info or peripheral byte
  always_ff @(posedge core_clk) begin
    if (rst || rst_l23) begin
      hold_r <= UNMAPPED_DATA;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // RAM data sit in the memory's own register, so all regions answer one cycle on
  // Both sources are flops; pick the one that served the read
  assign cpu_rdata = (src_r == SRC_RAM) ? ram_q : hold_r;

  // Writes aimed at the info area are dropped and flagged
  always_ff @(posedge core_clk) begin
    if (rst || rst_l23) begin
      info_wr_ignored <= 1'b0;
    end else begin
      info_wr_ignored <= cpu_req.wr && hit_info;
    end
  end

  // ----------------------------------------------------------------
  // Boot hold after Level 1 reset
  // ----------------------------------------------------------------
  // Boot hold state; a Level 2/3 reset leaves it alone
  boot_state_t boot_r;
  logic [31:0] settle_cnt_r;

  // Count the info settle time, then release code fetch
  always_ff @(posedge core_clk) begin
    if (rst) begin
      boot_r <= BOOT_SETTLE;
      settle_cnt_r <= 32'h0000_0000;
    end else begin
      case (boot_r)
        BOOT_SETTLE: begin
          if (settle_cnt_r == 32'(SETTLE_CYCLES - 1)) begin
            boot_r <= BOOT_RUN;
          end else begin
            settle_cnt_r <= settle_cnt_r + 32'h0000_0001;
          end
        end
        BOOT_RUN: begin
          boot_r <= BOOT_RUN;
        end
        default: begin
          boot_r <= BOOT_SETTLE;
        end
      endcase
    end
  end

  // Code fetch stays blocked until the info area has settled
  assign fetch_enable = (boot_r == BOOT_RUN);

endmodule

// ==== tb/data_space_props.sv ====
// Port checker for the data-space decoder.
// Assumes a bind onto data_space_decoder with a short settle count.
`timescale 1ns/10ps
module data_space_props
  import data_space_pkg::*;
#(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rst_l23,
  input data_space_pkg::xbus_req_t cpu_req,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_rvalid,
  input wire logic fetch_enable,
  input wire logic [data_space_pkg::INFO_AW-1:0] info_addr,
  input wire logic info_rd,
  input wire logic [7:0] info_rdata,
  input data_space_pkg::periph_req_t periph_a_req,
  input data_space_pkg::periph_req_t periph_b_req,
  input wire logic periph_a_rst,
  input wire logic periph_b_rst,
  input wire logic info_wr_ignored
);
  int cnt_r;
  logic in_info;
  assign in_info = cpu_req.addr >= INFO_BASE && cpu_req.addr <= INFO_LAST;
  // Cycles since Level 1 release, saturating
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 0;
    end else if (cnt_r < SETTLE_CYCLES + 8) begin
      cnt_r <= cnt_r + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || rst_l23); // Both reset levels clear the read path
  AST_RVALID: assert property (cpu_req.rd |=> cpu_rvalid)
    else $error("read not answered");
  AST_RVALID_PULSE: assert property (!cpu_req.rd |=> !cpu_rvalid)
    else $error("answer without read");
  AST_INFO_RD: assert property (info_rd == (cpu_req.rd && in_info))
    else $error("info strobe wrong");
  AST_INFO_ADDR: assert property (info_rd |-> info_addr == cpu_req.addr[9:0])
    else $error("info offset wrong");
  AST_INFO_DATA: assert property (info_rd |=> cpu_rdata == $past(info_rdata))
    else $error("info data not returned");
  AST_INFO_WR: assert property (cpu_req.wr && in_info |=> info_wr_ignored)
    else $error("info write not flagged");
  AST_L1_RST: assert property (disable iff (1'b0) periph_a_rst == rst)
    else $error("group A reset wrong");
  AST_ANY_RST: assert property (disable iff (1'b0) periph_b_rst == (rst | rst_l23))
    else $error("group B reset wrong");
  AST_FETCH_HOLD: assert property (fetch_enable |-> cnt_r >= SETTLE_CYCLES)
    else $error("fetch enabled early");
  AST_FETCH_BY: assert property (cnt_r == SETTLE_CYCLES + 4 |-> fetch_enable)
    else $error("fetch enabled late");
  AST_PA_WR: assert property (cpu_req.wr && cpu_req.addr[15:11] == 5'h04 |->
    periph_a_req.sel && periph_a_req.wr)
    else $error("group A write not routed");
  AST_PB_WR: assert property (cpu_req.wr && cpu_req.addr[15:11] == 5'h05 |->
    periph_b_req.sel && periph_b_req.wr)
    else $error("group B write not routed");
  AST_FETCH_KEEP: assert property (disable iff (rst) fetch_enable |=> fetch_enable)
    else $error("fetch dropped without Level 1 reset");
endmodule

bind data_space_decoder data_space_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_data_space_props (
  .core_clk(core_clk), .rst(rst), .rst_l23(rst_l23), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
  .cpu_rvalid(cpu_rvalid), .fetch_enable(fetch_enable), .info_addr(info_addr), .info_rd(info_rd),
  .info_rdata(info_rdata), .periph_a_req(periph_a_req), .periph_b_req(periph_b_req),
  .periph_a_rst(periph_a_rst),
  .periph_b_rst(periph_b_rst), .info_wr_ignored(info_wr_ignored)
);

// ==== tb/far_side_model.sv ====
// Model of the factory info array and two peripheral groups.
// Assumes it sits on the decoder's far-side ports, one clock.
`timescale 1ns/10ps
module far_side_model
  import data_space_pkg::*;
(
  input wire logic core_clk,
  input wire logic [data_space_pkg::INFO_AW-1:0] info_addr,
  input wire logic info_rd,
  output logic [7:0] info_rdata,
  input data_space_pkg::periph_req_t periph_a_req,
  input data_space_pkg::periph_req_t periph_b_req,
  input wire logic periph_a_rst,
  input wire logic periph_b_rst,
  output logic [7:0] periph_a_rdata,
  output logic [7:0] periph_b_rdata
);
  logic [7:0] a_r;
  logic [7:0] b_r;
  // Info bytes fixed per address, peripheral bytes from registers; inverted when not read
  assign info_rdata = info_rd ? (info_addr[7:0] ^ 8'h5A) : ~(info_addr[7:0] ^ 8'h5A);
  assign periph_a_rdata = periph_a_req.rd ? a_r : ~a_r;
  assign periph_b_rdata = periph_b_req.rd ? b_r : ~b_r;
  // Group A cleared by Level 1 only
  always_ff @(posedge core_clk) begin
    if (periph_a_rst) begin
      a_r <= 8'h3C;
    end else if (periph_a_req.sel && periph_a_req.wr) begin
      a_r <= periph_a_req.wdata;
    end
  end
  // Group B cleared by any level
  always_ff @(posedge core_clk) begin
    if (periph_b_rst) begin
      b_r <= 8'h3C;
    end else if (periph_b_req.sel && periph_b_req.wr) begin
      b_r <= periph_b_req.wdata;
    end
  end
endmodule

// ==== tb/tb_data_space_decoder.sv ====
// Self-checking bench for the data-space decoder.
// Assumes the far-side model and the bound checker are compiled too.
`timescale 1ns/10ps
module tb_data_space_decoder;
  import data_space_pkg::*;
  localparam int SETTLE = 8;
  logic core_clk = 0, rst = 1, rst_l23 = 0;
  xbus_req_t req = '0;
  logic [7:0] cpu_rdata, periph_a_rdata, periph_b_rdata, info_rdata;
  logic cpu_rvalid, fetch_enable, info_rd, periph_a_rst, periph_b_rst, info_wr_ignored;
  logic [INFO_AW-1:0] info_addr;
  periph_req_t periph_a_req, periph_b_req;
  int fail_count = 0, comparisons = 0;
  data_space_decoder #(.SETTLE_CYCLES(SETTLE)) i_data_space_decoder (.core_clk(core_clk), .rst(rst),
    .rst_l23(rst_l23), .cpu_req(req), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .fetch_enable(fetch_enable), .info_addr(info_addr), .info_rd(info_rd), .info_rdata(info_rdata),
    .periph_a_req(periph_a_req), .periph_b_req(periph_b_req), .periph_a_rdata(periph_a_rdata),
    .periph_b_rdata(periph_b_rdata), .periph_a_rst(periph_a_rst), .periph_b_rst(periph_b_rst),
    .info_wr_ignored(info_wr_ignored));
  far_side_model i_far_side_model (.core_clk(core_clk), .info_addr(info_addr), .info_rd(info_rd),
    .info_rdata(info_rdata), .periph_a_req(periph_a_req), .periph_b_req(periph_b_req),
    .periph_a_rst(periph_a_rst), .periph_b_rst(periph_b_rst), .periph_a_rdata(periph_a_rdata),
    .periph_b_rdata(periph_b_rdata));
  initial forever #10 core_clk = ~core_clk;
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // One bus cycle, request held through the taking edge
  task go(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
    req = '{r, w, a, d};
    @(posedge core_clk);
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    go(1, 0, a, 8'h00);
    chk("rvalid", 8'h01, {7'h00, cpu_rvalid});
    chk("rdata", e, cpu_rdata);
  endtask
  // Reset for two edges, then one idle edge so the next reset or request never shares the release step
  task rs(input logic l1);
    if (l1) begin
      rst = 1;
    end else begin
      rst_l23 = 1;
    end
    go(0, 0, 16'h0000, 8'h00);
    @(posedge core_clk);
    #1;
    rst = 0;
    rst_l23 = 0;
    go(0, 0, 16'h0000, 8'h00);
  endtask
  task t_ram;
    go(0, 1, 16'h0000, 8'hA1);
    go(0, 1, 16'h0FFF, 8'h5E);
    rd(16'h0FFF, 8'h5E);
    rd(16'h1000, UNMAPPED_DATA);
    rs(1);
    rs(0);
    rd(16'h0000, 8'hA1);
    rd(16'h0FFF, 8'h5E);
    $display("ram test done");
  endtask
  // Field offsets fold into the 10-bit window: field 0x401 sits at 3001h, group 1 checksum at 304Ch
  task t_info;
    rd(16'h3001, 8'h01 ^ 8'h5A);
    rd(16'h33FF, 8'hFF ^ 8'h5A);
    rd(16'h3020, 8'h20 ^ 8'h5A);
    rd(16'h304C, 8'h4C ^ 8'h5A);
    go(0, 1, 16'h3001, 8'h00);
    chk("wr_ignored", 8'h01, {7'h00, info_wr_ignored});
    rd(16'h3001, 8'h01 ^ 8'h5A);
    $display("info test done");
  endtask
  task t_periph;
    go(0, 1, 16'h2005, 8'h11);
    go(0, 1, 16'h2805, 8'h22);
    rs(0);
    rd(16'h2005, 8'h11);
    rd(16'h2805, 8'h3C);
    rs(1);
    rd(16'h2005, 8'h3C);
    $display("periph test done");
  endtask
  // Fetch rises SETTLE edges after the last Level 1 edge; rs returns one edge past release
  task t_boot;
    rs(1);
    repeat (SETTLE - 2) @(posedge core_clk);
    #1 chk("fetch_low", 8'h00, {7'h00, fetch_enable});
    @(posedge core_clk);
    #1 chk("fetch_high", 8'h01, {7'h00, fetch_enable});
    rs(0);
    chk("fetch_kept", 8'h01, {7'h00, fetch_enable});
    $display("boot test done");
  endtask
  // Tests need about 45 cycles; 200 cycles without a verdict means a hang
  initial begin
    #4000;
    fail_count++;
    results;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst = 0;
    t_ram;
    t_info;
    t_periph;
    t_boot;
    results;
  end
endmodule
